/* File: src/usn_uart.sv */
// Purpose: Eleven-bit frame serial port with Wishbone register access
// Assumes: 250 MHz clk_i, synchronous active-high reset
// Notes:   Fixed or timer-based bit clock; multiprocessor address filter
// Notes on behaviour
// - Frame is low start, eight data LSB first, ninth bit, high stop.
// - Sent ninth bit equals the software transmit ninth-bit field.
// - Fixed mode bit rate is clock/64, or clock/32 with doubling set.
// - Variable mode uses timer one at clock/12 or timer two overflows.
// - Buffer write loads ninth bit into shift register and requests send.
// - Sending starts only at the next divide-by-16 rollover.
// - Start bit first, data output a bit later, first shift a bit later.
// - First shift inserts a one at the top, later shifts insert zeroes.
// - Final shift ends sending and sets transmit done at rollover eleven.
// - Receive pin sampled at 16x; falling edge clears counter, loads ones.
// - Each bit is the majority of samples at counter states 7, 8, 9.
// - A start bit not read as zero returns the receiver to hunting.
// - Start bit at the far stage triggers a last shift and the load.
// - Frame kept only if receive done clear and filter off or ninth set.
// - Kept frame loads ninth bit, data byte, and sets receive done.
// - One bit time after the final shift the receiver hunts again.
// - The received stop bit value changes nothing.
// - Reset clears the baud doubling bit.
// - In variable mode, timer two clocks transmit or receive when its select bit is set.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
module usn_uart
   import usn_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire usn_wb_req_s  wb_i,
   output logic              wb_ack_o,
   output logic [31:0]       wb_dat_o,
   input  wire logic         rxd_i,
   output logic              txd_o
);
   // Registers
   logic        var_mode, multiproc_filter, tx_ninth_bit, rx_ninth_bit;
   logic        tx_done_flag, rx_done_flag, baud_double;
   logic        tx_clock_from_timer_two, rx_clock_from_timer_two;
   logic [7:0]  t1_rld, serial_buffer;
   logic [15:0] t2_rld;
   logic [31:0] rd_word;

   // Transmit and receive state
   usn_tx_e     tx_state;
   usn_rx_e     rx_state;
   logic [8:0]  tx_sh, rx_sh;
   logic [3:0]  tx_cnt, rx_cnt, tx_rolls;
   logic        tx_req, tx_first, rx_last, smp_a, smp_b;
   logic [2:0]  fdiv;
   logic        hlf_tx, hlf_rx, t1_ovf, t2_ovf, rx_s;

   function automatic logic pick(input logic vm, t2s, o1, o2, fx);
      return vm ? (t2s ? o2 : o1) : fx;
   endfunction : pick

   function automatic logic maj(input logic a, b, c);
      return (a & b) | (a & c) | (b & c);
   endfunction : maj

   // Bus decode; writes land at the edge where ack is high
   wire hit     = wb_i.cyc & wb_i.stb & ~wb_ack_o;
   wire wr      = wb_i.cyc & wb_i.stb & wb_ack_o & wb_i.we;
   wire wr_lo   = wr & wb_i.sel[0];
   wire wr_ctrl = wr_lo && (wb_i.adr == ADR_CTRL);
   wire wr_buf  = wr_lo && (wb_i.adr == ADR_BUF);
   wire wr_pwr  = wr_lo && (wb_i.adr == ADR_PWR);
   wire wr_t2c  = wr_lo && (wb_i.adr == ADR_T2CTL);
   wire wr_t1r  = wr_lo && (wb_i.adr == ADR_T1RLD);
   wire wr_t2r  = wr && (wb_i.adr == ADR_T2RLD);

   // Bit clock sources
   wire [2:0] fdiv_top = baud_double ? FIX_DIV_FAST : FIX_DIV_SLOW;
   wire fix_tick = (fdiv == fdiv_top - 3'h1);
   wire src_tx   = pick(var_mode, tx_clock_from_timer_two, t1_ovf, t2_ovf, fix_tick);
   wire src_rx   = pick(var_mode, rx_clock_from_timer_two, t1_ovf, t2_ovf, fix_tick);
   wire tick_tx  = src_tx & (~var_mode | baud_double | hlf_tx);
   wire tick_rx  = src_rx & (~var_mode | baud_double | hlf_rx);

   // Transmit decode
   wire tx_roll = tick_tx && (tx_cnt == BIT_LAST);
   wire tx_fin  = tx_roll && (tx_state == TX_DATA) && !tx_first
                  && (tx_sh[8:1] == 8'h01);

   // Receive decode
   wire fall     = tick_rx & rx_last & ~rx_s;
   wire bit_tm   = tick_rx && (rx_cnt == SAMP_C);
   wire rbit     = maj(smp_a, smp_b, rx_s);
   wire rx_first = (rx_sh == SHIFT_ONES);
   wire bit_ok   = bit_tm && (rx_state == RX_BITS);
   wire rx_fin   = bit_ok && !rx_sh[0];
   wire accept   = rx_fin && !rx_done_flag && (!multiproc_filter || rbit);

   // Timers for the variable-rate mode
   usn_timer #(.W(8), .PRE(T1_PRE)) u_t1 (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rld_i (t1_rld),
      .ovf_o (t1_ovf)
   );

   usn_timer #(.W(16), .PRE(T2_PRE)) u_t2 (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rld_i (t2_rld),
      .ovf_o (t2_ovf)
   );

   usn_sync u_rxs (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (rxd_i),
      .lvl_o (rx_s)
   );

   // Read data mux
   always_comb begin
      rd_word = 32'h0;
      case (wb_i.adr)
         ADR_CTRL: begin
            rd_word[CTRL_VAR] = var_mode;
            rd_word[CTRL_MPF] = multiproc_filter;
            rd_word[CTRL_TX9] = tx_ninth_bit;
            rd_word[CTRL_RX9] = rx_ninth_bit;
            rd_word[CTRL_TXD] = tx_done_flag;
            rd_word[CTRL_RXD] = rx_done_flag;
         end
         ADR_BUF:   rd_word[7:0] = serial_buffer;
         ADR_PWR:   rd_word[PWR_DBL] = baud_double;
         ADR_T2CTL: begin
            rd_word[T2_RCLK] = rx_clock_from_timer_two;
            rd_word[T2_TX_CLOCK_FROM_TIMER_TWO] = tx_clock_from_timer_two;
         end
         ADR_T1RLD: rd_word[7:0] = t1_rld;
         ADR_T2RLD: rd_word[15:0] = t2_rld;
         default:   rd_word = 32'h0;
      endcase
   end

   // Bus answer: ack one cycle after the request, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= hit;
         if (hit) begin
            wb_dat_o <= rd_word;
         end
      end
   end

   // Software control bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         var_mode                <= 1'b0;
         multiproc_filter        <= 1'b0;
         tx_ninth_bit            <= 1'b0;
         baud_double             <= 1'b0;
         tx_clock_from_timer_two <= 1'b0;
         rx_clock_from_timer_two <= 1'b0;
         t1_rld                  <= RST_T1RLD;
         t2_rld                  <= RST_T2RLD;
      end else begin
         if (wr_ctrl) begin
            var_mode         <= wb_i.dat[CTRL_VAR];
            multiproc_filter <= wb_i.dat[CTRL_MPF];
            tx_ninth_bit     <= wb_i.dat[CTRL_TX9];
         end
         if (wr_pwr) begin
            baud_double <= wb_i.dat[PWR_DBL];
         end
         if (wr_t2c) begin
            tx_clock_from_timer_two <= wb_i.dat[T2_TX_CLOCK_FROM_TIMER_TWO];
            rx_clock_from_timer_two <= wb_i.dat[T2_RCLK];
         end
         if (wr_t1r) begin
            t1_rld <= wb_i.dat[7:0];
         end
         if (wr_t2r && wb_i.sel[0]) begin
            t2_rld[7:0] <= wb_i.dat[7:0];
         end
         if (wr_t2r && wb_i.sel[1]) begin
            t2_rld[15:8] <= wb_i.dat[15:8];
         end
      end
   end

   // Done flags: a hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
      end else begin
         tx_done_flag <= tx_fin | (tx_done_flag & ~(wr_ctrl & ~wb_i.dat[CTRL_TXD]));
         rx_done_flag <= accept | (rx_done_flag & ~(wr_ctrl & ~wb_i.dat[CTRL_RXD]));
      end
   end

   // Fixed divider and halving stages for timer overflows
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fdiv   <= 3'h0;
         hlf_tx <= 1'b0;
         hlf_rx <= 1'b0;
      end else begin
         fdiv   <= fix_tick ? 3'h0 : fdiv + 3'h1;
         hlf_tx <= hlf_tx ^ (src_tx & var_mode);
         hlf_rx <= hlf_rx ^ (src_rx & var_mode);
      end
   end

   // Transmit sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state <= TX_IDLE;
         tx_sh    <= 9'h0;
         tx_cnt   <= 4'h0;
         tx_req   <= 1'b0;
         tx_first <= 1'b0;
      end else begin
         if (tick_tx) begin
            tx_cnt <= tx_cnt + 4'h1;
         end
         case (tx_state)
            TX_IDLE: begin
               if (tx_roll && tx_req) begin
                  tx_state <= TX_START;
                  tx_req   <= 1'b0;
               end
            end
            TX_START: begin
               if (tx_roll) begin
                  tx_state <= TX_DATA;
                  tx_first <= 1'b1;
               end
            end
            TX_DATA: begin
               if (tx_roll) begin
                  tx_sh    <= {tx_first, tx_sh[8:1]};
                  tx_first <= 1'b0;
                  if (tx_fin) begin
                     tx_state <= TX_IDLE;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
         if (wr_buf) begin
            tx_sh  <= {tx_ninth_bit, wb_i.dat[7:0]};
            tx_req <= 1'b1;
         end
      end
   end

   // Line driver: low start, data from shift output, idle high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txd_o <= 1'b1;
      end else begin
         txd_o <= (tx_state == TX_START) ? 1'b0 :
                  (tx_state == TX_DATA) ? tx_sh[0] : 1'b1;
      end
   end

   // Receive sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_state      <= RX_HUNT;
         rx_sh         <= SHIFT_ONES;
         rx_cnt        <= 4'h0;
         rx_last       <= 1'b1;
         smp_a         <= 1'b1;
         smp_b         <= 1'b1;
         serial_buffer <= 8'h0;
         rx_ninth_bit  <= 1'b0;
      end else begin
         if (tick_rx) begin
            rx_last <= rx_s;
            rx_cnt  <= rx_cnt + 4'h1;
            if (rx_cnt == SAMP_A) begin
               smp_a <= rx_s;
            end
            if (rx_cnt == SAMP_B) begin
               smp_b <= rx_s;
            end
         end
         case (rx_state)
            RX_HUNT: begin
               if (fall) begin
                  rx_state <= RX_BITS;
                  rx_cnt   <= 4'h0;
                  rx_sh    <= SHIFT_ONES;
               end
            end
            RX_BITS: begin
               if (bit_ok && rx_first && rbit) begin
                  rx_state <= RX_HUNT;
               end else if (bit_ok) begin
                  rx_sh <= {rbit, rx_sh[8:1]};
                  if (rx_fin) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (bit_tm) begin
                  rx_state <= RX_HUNT;
               end
            end
            default: rx_state <= RX_HUNT;
         endcase
         if (accept) begin
            serial_buffer <= rx_sh[8:1];
            rx_ninth_bit  <= rbit;
         end
      end
   end

   // Rollovers since the last buffer write, for checking only
   always_ff @(posedge clk_i) begin
      if (rst_i || wr_buf) begin
         tx_rolls <= 4'h0;
      end else if (tx_roll) begin
         tx_rolls <= tx_rolls + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ninth_load: assert property (wr_buf |=> tx_sh[8] == $past(tx_ninth_bit) && tx_req)
      else $error("ninth bit or request not loaded");
   a_start_aligned: assert property ($rose(tx_state == TX_START) |-> $past(tx_roll))
      else $error("send phase not on rollover");
   a_start_low: assert property (tx_state == TX_START |=> txd_o == 1'b0)
      else $error("start bit not low");
   a_first_shift: assert property (tx_roll && tx_state == TX_DATA && tx_first |=> tx_sh[8])
      else $error("stop bit not inserted");
   a_done_count: assert property (tx_fin |-> tx_rolls == TX_DONE_ROLL - 4'h1 ##1 tx_done_flag)
      else $error("transmit done at wrong rollover");
   a_slow_rate: assert property (!var_mode && !baud_double && fix_tick |=> (!fix_tick || baud_double)[*3])
      else $error("fixed rate spacing wrong");
   a_edge_reset: assert property (rx_state == RX_HUNT && fall |=> rx_cnt == 4'h0
                                  && rx_sh == SHIFT_ONES)
      else $error("edge did not restart receiver");
   a_false_start: assert property (bit_ok && rx_first && rbit |=> rx_state == RX_HUNT)
      else $error("false start not rejected");
   a_frame_lost: assert property (rx_fin && !accept |=> $stable(serial_buffer)
                                  && $stable(rx_ninth_bit))
      else $error("rejected frame was loaded");
   a_frame_kept: assert property (accept |=> rx_done_flag && serial_buffer == $past(rx_sh[8:1]))
      else $error("accepted frame not loaded");
   a_t2_select: assert property (var_mode && tx_clock_from_timer_two |-> src_tx == t2_ovf)
      else $error("timer two not selected");
   a_dbl_reset: assert property ($fell(rst_i) |-> !baud_double)
      else $error("baud doubling not cleared");

   c_tx_done: cover property (tx_fin);
   c_rx_accept: cover property (accept);
   c_false_start: cover property (bit_ok && rx_first && rbit);
   c_filter_drop: cover property (rx_fin && multiproc_filter && !rbit);

endmodule : usn_uart

/* File: common/usn_pkg.sv */
// Purpose: Shared constants and types of the nine-bit serial port
// Assumes: Wishbone classic bus, 32-bit data, byte addresses
// Notes:   Every offset, field position and count lives here
package usn_pkg;

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_BUF    = 8'h04;
   localparam logic [7:0] ADR_PWR    = 8'h08;
   localparam logic [7:0] ADR_T2CTL  = 8'h0C;
   localparam logic [7:0] ADR_T1RLD  = 8'h10;
   localparam logic [7:0] ADR_T2RLD  = 8'h14;

   // Field positions
   localparam int CTRL_VAR  = 7;   // Variable-rate mode select
   localparam int CTRL_MPF  = 5;   // Multiprocessor filter
   localparam int CTRL_TX9  = 3;   // Transmit ninth bit
   localparam int CTRL_RX9  = 2;   // Received ninth bit
   localparam int CTRL_TXD  = 1;   // Transmit done flag
   localparam int CTRL_RXD  = 0;   // Receive done flag
   localparam int PWR_DBL   = 7;   // Baud doubling
   localparam int T2_RCLK   = 5;   // Receive clock from timer two
   localparam int T2_TX_CLOCK_FROM_TIMER_TWO   = 4;   // Transmit clock from timer two

   // Reset values
   localparam logic [7:0]  RST_T1RLD = 8'h00;
   localparam logic [15:0] RST_T2RLD = 16'h0000;
   localparam logic [8:0]  SHIFT_ONES = 9'h1FF;

   // Timing counts, in system clocks, 16x ticks or bit rollovers
   localparam logic [2:0] FIX_DIV_SLOW = 3'h4;  // 64 / 16
   localparam logic [2:0] FIX_DIV_FAST = 3'h2;  // 32 / 16
   localparam int         T1_PRE       = 12;
   localparam int         T2_PRE       = 2;
   localparam logic [3:0] BIT_LAST     = 4'hF;
   localparam logic [3:0] SAMP_A       = 4'h7;
   localparam logic [3:0] SAMP_B       = 4'h8;
   localparam logic [3:0] SAMP_C       = 4'h9;
   localparam logic [3:0] TX_DONE_ROLL = 4'hB;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } usn_wb_req_s;

   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} usn_tx_e;
   typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_STOP} usn_rx_e;

endpackage : usn_pkg

/* File: src/usn_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Pin idles high
// Notes:   Level changes once stages two and three agree
module usn_sync
   import usn_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      lvl_o
);
   logic [2:0] stg;

   // Shift chain; stage one feeds only stage two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stg   <= 3'h7;
         lvl_o <= 1'b1;
      end else begin
         stg <= {stg[1:0], pin_i};
         if (stg[1] == stg[2]) begin
            lvl_o <= stg[2];
         end
      end
   end
endmodule : usn_sync

/* File: src/usn_timer.sv */
// Purpose: Prescaled up-counter with auto-reload and overflow pulse
// Assumes: Reload value is software owned
// Notes:   Overflow pulse lasts one clock
module usn_timer
   import usn_pkg::*;
#(
   parameter int W   = 8,
   parameter int PRE = 12
)(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] rld_i,
   output logic              ovf_o
);
   logic [3:0]   pre;
   logic [W-1:0] cnt;
   logic [W-1:0] rld_seen;
   wire          step    = (pre == 4'(PRE - 1));
   wire          rld_new = (rld_i != rld_seen);

   // Prescaler, counter and reload; a new reload value restarts the count
   // at once, so software need not wait a whole wrap for the first overflow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre      <= 4'h0;
         cnt      <= '0;
         rld_seen <= '0;
         ovf_o    <= 1'b0;
      end else begin
         rld_seen <= rld_i;
         pre      <= step ? 4'h0 : pre + 4'h1;
         ovf_o    <= step && (&cnt);
         if (rld_new) begin
            cnt <= rld_i;
         end else if (step) begin
            cnt <= (&cnt) ? rld_i : cnt + W'(1);
         end
      end
   end
endmodule : usn_timer

/* File: bench/usn_remote.sv */
// Purpose: Remote serial station facing the nine-bit port
// Assumes: Eleven-bit frames, bit time given in clocks
// Notes:   Receive line idles high, as with a pull-up
module usn_remote (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle line level
   initial rxd_o = 1'b1;

   // Send one frame; nz flips the line briefly near the sample point
   task automatic send_frame(input logic [7:0] d, input logic n9, input logic stp,
                             input int blen, input logic nz);
      logic [10:0] f;
      f = {stp, n9, d, 1'b0};
      for (int b = 0; b < 11; b++) begin
         for (int c = 0; c < blen; c++) begin
            @(posedge clk_i);
            rxd_o <= (nz && b < 10 && c >= 26 && c < 30) ? ~f[b] : f[b];
         end
      end
      @(posedge clk_i);
      rxd_o <= 1'b1;
      repeat (blen) @(posedge clk_i);
   endtask : send_frame

   // Short low pulse that must not pass as a start bit
   task automatic pulse_low(input int n);
      @(posedge clk_i);
      rxd_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask : pulse_low

   // Capture a frame; start length gives the bit time (d0 must be one)
   task automatic catch_frame(output logic [10:0] f, output int blen);
      int n;
      n = 0;
      blen = 0;
      f = '1;
      while (txd_i !== 1'b0 && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      while (txd_i === 1'b0 && blen < 20000) begin
         @(posedge clk_i);
         blen++;
      end
      f[0] = 1'b0;
      repeat (blen / 2) @(posedge clk_i);
      for (int b = 1; b < 11; b++) begin
         f[b] = txd_i;
         repeat (blen) @(posedge clk_i);
      end
   endtask : catch_frame
endmodule : usn_remote

/* File: bench/usn_uart_tb.sv */
// Purpose: Self-checking bench of the nine-bit serial port
// Assumes: 4 ns clock, reset held six cycles
// Notes:   Remote station model drives rxd and captures txd
module usn_uart_tb
   import usn_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   usn_wb_req_s wb  = '0;
   logic        wb_ack;
   logic [31:0] wb_dat;
   logic        rxd;
   logic        txd;
   int          bad_count = 0;
   int          n_compared = 0;

   // Clock
   always #2 clk = ~clk;

   usn_uart usn_uart_i (
      .clk_i    (clk),
      .rst_i    (rst),
      .wb_i     (wb),
      .wb_ack_o (wb_ack),
      .wb_dat_o (wb_dat),
      .rxd_i    (rxd),
      .txd_o    (txd)
   );

   usn_remote usn_remote_i (
      .clk_i (clk),
      .txd_i (txd),
      .rxd_o (rxd)
   );

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : chk

   // One classic cycle; request held until ack is seen at an edge
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] sel, output logic [31:0] r);
      int n;
      n = 0;
      wb <= '{1'b1, 1'b1, we, sel, a, d};
      @(posedge clk);
      while (wb_ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      r = wb_dat;
      wb <= '0;
      @(posedge clk);
      if (n >= 50) begin
         bad_count++;
         final_report();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, 4'h1, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, 4'hF, r);
   endtask : rd

   // Send a byte and judge the frame seen on the line
   task automatic tx_check(input logic [7:0] cfg, input logic [7:0] d, input int blen_exp);
      logic [10:0] f;
      int          blen;
      logic [31:0] r;
      wr(ADR_CTRL, {24'h0, cfg} | 32'h3);
      fork
         wr(ADR_BUF, {24'h0, d});
         usn_remote_i.catch_frame(f, blen);
      join
      chk(32'(f), 32'({1'b1, cfg[CTRL_TX9], d, 1'b0}), "tx frame");
      chk(32'(blen), 32'(blen_exp), "tx bit time");
      rd(ADR_CTRL, r);
      chk(32'(r[CTRL_TXD]), 32'h1, "tx done");
      wr(ADR_CTRL, {24'h0, cfg} | 32'h1);
   endtask : tx_check

   task automatic rx_frame(input logic [7:0] d, input logic n9, input logic stp, input int blen,
                           input logic nz, output logic [31:0] c, output logic [31:0] b);
      usn_remote_i.send_frame(d, n9, stp, blen, nz);
      rd(ADR_CTRL, c);
      rd(ADR_BUF, b);
   endtask : rx_frame

   task automatic s_reset();
      logic [7:0]  adrs [7] = '{ADR_CTRL, ADR_BUF, ADR_PWR, ADR_T2CTL, ADR_T1RLD, ADR_T2RLD, 8'h40};
      logic [31:0] r;
      wr(8'h40, 32'hFF);
      foreach (adrs[i]) begin
         rd(adrs[i], r);
         chk(r, 32'h0, "reset value");
      end
      wr(ADR_CTRL, 32'h4);
      rd(ADR_CTRL, r);
      chk(r, 32'h0, "ro ninth bit");
   endtask : s_reset

   task automatic s_tx_fixed();
      tx_check(8'h08, 8'hA5, 64);
      wr(ADR_PWR, 32'h80);
      tx_check(8'h00, 8'h33, 32);
   endtask : s_tx_fixed

   task automatic s_timers();
      logic [31:0] c;
      logic [31:0] b;
      wr(ADR_T1RLD, 32'hFF);
      tx_check(8'h80, 8'h81, 192);
      wr(ADR_T2CTL, 32'h30);
      xfer(1'b1, ADR_T2RLD, 32'hFFFF, 4'h3, c);
      tx_check(8'h88, 8'h35, 32);
      rx_frame(8'h5C, 1'b1, 1'b1, 32, 1'b0, c, b);
      chk(32'(b[7:0]), 32'h5C, "rx timer two");
      wr(ADR_PWR, 32'h0);
      tx_check(8'h88, 8'h53, 64);
      wr(ADR_CTRL, 32'h2);
      wr(ADR_T2CTL, 32'h0);
      wr(ADR_PWR, 32'h0);
   endtask : s_timers

   task automatic s_rx();
      logic [31:0] c;
      logic [31:0] b;
      rx_frame(8'hC3, 1'b0, 1'b0, 64, 1'b1, c, b);
      chk(32'(c[2:0]), 32'h1, "rx flags");
      chk(32'(b[7:0]), 32'hC3, "rx data");
      rx_frame(8'h5A, 1'b1, 1'b1, 64, 1'b0, c, b);
      chk(32'(b[7:0]), 32'hC3, "blocked data");
      chk(32'(c[CTRL_RX9]), 32'h0, "blocked ninth");
      wr(ADR_CTRL, 32'h2);
      rx_frame(8'h7E, 1'b1, 1'b1, 64, 1'b0, c, b);
      chk(32'(c[2:0]), 32'h5, "rx ninth");
      wr(ADR_CTRL, 32'h22);
      rx_frame(8'h11, 1'b0, 1'b1, 64, 1'b0, c, b);
      chk(32'(c[CTRL_RXD]), 32'h0, "filtered");
      rx_frame(8'h22, 1'b1, 1'b1, 64, 1'b0, c, b);
      chk(32'(b[7:0]), 32'h22, "address byte");
      wr(ADR_CTRL, 32'h2);
   endtask : s_rx

   task automatic s_false_start();
      logic [31:0] c;
      logic [31:0] b;
      usn_remote_i.pulse_low(16);
      repeat (128) @(posedge clk);
      rd(ADR_CTRL, c);
      chk(32'(c[CTRL_RXD]), 32'h0, "false start");
      rx_frame(8'h96, 1'b1, 1'b1, 64, 1'b0, c, b);
      chk(32'(b[7:0]), 32'h96, "after glitch");
   endtask : s_false_start

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_reset();
      s_tx_fixed();
      s_timers();
      s_rx();
      s_false_start();
      final_report();
   end
endmodule : usn_uart_tb
